// file: apm_ctrl.sv
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Grounded select pin means register control
// - Two-bit power state field, shutdown default
// - Power state change keeps other registers
// - Active entry uses ordered click-free power-up
// - Shutdown ramps down (from the gate goes straight off), keeps registers, resumes
// - Clock mode powers with clocks, down without
// - Soft reset powers down, restores defaults, clears
// - Status bit one shows live active state
// - Efficiency select enables low-power and gate modes
// - Gate entry needs full hold below threshold
// - Gate stops switching, outputs low, float select
// - Gate flag high only while gated
// - Gate wakes above threshold, samples buffered
// - Gate threshold steps 5 dB, default 105
// - Gate hold 10/50/100/1000 ms, default 50
// - Low-power mode after 24-bit hold below threshold
// - Low-power exits above threshold, output unchanged
// - Dual-rail enable picks switching rail itself
// - Low rail after full hold below threshold
// - High rail above threshold plus hysteresis
// - Low-rail hold 100us/500us/5ms/50ms, default 500us
// - Gate exit uses ordered power-up, entry stops at once
// - Dual-rail enable resets to one
module apm_ctrl #(
  parameter int unsigned CLK_LOSS = apm_pkg::CLK_LOSS_CYC,
  parameter int unsigned HOLD_DIV = 1
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_config_select_pin_one,
  input  wire logic        i_bclk,
  input  wire logic        i_frame_sync,
  input  wire logic        i_sample_valid,
  input  wire logic [23:0] i_sample,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             o_analog_en,
  output logic             o_pwm_en,
  output logic             o_ramp_down,
  output logic             o_outputs_float,
  output logic             o_low_rail,
  output logic             o_sample_hold
);
  import apm_pkg::*;

  typedef enum logic [2:0] {
    SEQ_OFF     = 3'b000,
    SEQ_POWERUP = 3'b001,
    SEQ_RAMPUP  = 3'b010,
    SEQ_PLAY    = 3'b011,
    SEQ_RAMPDN  = 3'b100,
    SEQ_POWERDN = 3'b101,
    SEQ_GATED   = 3'b110
  } apm_seq_t;

  // Hold times in cycles, divisible down for simulation
  function automatic logic [CNT_W-1:0] gate_cycles(input logic [1:0] sel);
    gate_cycles = CNT_W'((CLK_HZ / 1000 * GATE_HOLD_MS[sel]) / HOLD_DIV);
  endfunction
  function automatic logic [CNT_W-1:0] rail_cycles(input logic [1:0] sel);
    rail_cycles = CNT_W'((CLK_HZ / 1000000 * LR_HOLD_US[sel]) / HOLD_DIV);
  endfunction
  function automatic logic [23:0] magnitude(input logic [23:0] s);
    magnitude = s[23] ? 24'(~s + 24'h000001) : s;
  endfunction

  logic [1:0]  pwr_reg;
  logic        srst_reg;
  logic        float_reg;
  logic [1:0]  eff_sel_reg;
  logic [2:0]  gate_thr_reg;
  logic [1:0]  gate_hold_reg;
  logic [1:0]  lr_hold_reg;
  logic        dual_reg;
  logic [23:0] lp_thr_reg;
  logic [23:0] lp_time_reg;
  logic [23:0] lr_thr_reg;
  logic [23:0] lr_hyst_reg;
  apm_seq_t    seq_reg;
  logic [15:0] step_reg;
  logic [2:0]  bclk_sync_reg;
  logic [2:0]  fs_sync_reg;
  logic        fs_prev_reg;
  logic [31:0] loss_reg;
  logic        clk_ok_reg;
  logic [23:0] mag_reg;
  logic        mag_valid_reg;
  logic [CNT_W-1:0] gate_cnt_reg;
  logic [CNT_W-1:0] lr_cnt_reg;
  logic [23:0] lp_cnt_reg;
  logic        gate_quiet_reg;
  logic        lp_reg;
  logic        pend_reg;

  logic wr;
  logic rd;
  logic reg_en;
  logic want_on;
  logic fs_now;
  assign wr     = psel && penable && pwrite;
  assign rd     = psel && penable && !pwrite;
  // Pin tied low enables register control; otherwise writes ignored
  assign reg_en = !i_config_select_pin_one;
  assign fs_now = fs_sync_reg[2];

  // Pin inputs: change accepted once stages two and three agree
  always_ff @(posedge i_clk) begin
    bclk_sync_reg <= {bclk_sync_reg[1:0], i_bclk};
    fs_sync_reg   <= {fs_sync_reg[1:0], i_frame_sync};
    // Reset to idle low so no false frame edge follows reset
    if (i_reset) begin
      fs_prev_reg <= 1'b0;
    end else if (fs_sync_reg[1] == fs_sync_reg[2]) begin
      fs_prev_reg <= fs_now;
    end
  end

  // Clock presence: frame edges keep a loss counter reset
  always_ff @(posedge i_clk) begin
    if (i_reset || srst_reg) begin
      loss_reg   <= '0;
      clk_ok_reg <= 1'b0;
    end else if (fs_sync_reg[1] == fs_sync_reg[2] && fs_now != fs_prev_reg) begin
      loss_reg   <= '0;
      clk_ok_reg <= 1'b1;
    end else if (loss_reg >= CLK_LOSS) begin
      clk_ok_reg <= 1'b0;
    end else begin
      loss_reg <= loss_reg + 32'h00000001;
    end
  end

  // Configuration registers; soft reset restores all defaults
  always_ff @(posedge i_clk) begin
    if (i_reset || srst_reg) begin
      pwr_reg       <= RST_PWR;
      srst_reg      <= 1'b0;
      float_reg     <= 1'b0;
      eff_sel_reg   <= 2'h0;
      gate_thr_reg  <= RST_GATE_THR;
      gate_hold_reg <= RST_GATE_HOLD;
      lr_hold_reg   <= RST_LR_HOLD;
      dual_reg      <= RST_DUAL_RAIL;
      lp_thr_reg    <= RST_LP_THR;
      lp_time_reg   <= RST_LP_TIME;
      lr_thr_reg    <= RST_LR_THR;
      lr_hyst_reg   <= RST_LR_HYST;
    end else if (wr && reg_en) begin
      // Each offset touches only its own fields
      unique case (paddr)
        ADDR_CTRL: begin
          pwr_reg   <= pwdata[CTRL_PWR_LSB +: 2];
          srst_reg  <= pwdata[CTRL_SRST_BIT];
          float_reg <= pwdata[CTRL_FLOAT_BIT];
        end
        ADDR_EFF: begin
          eff_sel_reg   <= pwdata[EFF_SEL_LSB +: 2];
          gate_thr_reg  <= pwdata[EFF_GTHR_LSB +: 3];
          gate_hold_reg <= pwdata[EFF_GHOLD_LSB +: 2];
          lr_hold_reg   <= pwdata[EFF_LRHOLD_LSB +: 2];
          dual_reg      <= pwdata[EFF_DUAL_BIT];
        end
        ADDR_LP_THR:  lp_thr_reg  <= pwdata[23:0];
        ADDR_LP_TIME: lp_time_reg <= pwdata[23:0];
        ADDR_LR_THR:  lr_thr_reg  <= pwdata[23:0];
        ADDR_LR_HYST: lr_hyst_reg <= pwdata[23:0];
        default: ;
      endcase
    end
  end

  // Reserved code 01 is treated as a shutdown request
  assign want_on = (pwr_reg == PWR_ACTIVE) || (pwr_reg == PWR_CLOCKED && clk_ok_reg);

  // Per-sample magnitude, latched once each sample period
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mag_reg       <= '0;
      mag_valid_reg <= 1'b0;
    end else begin
      mag_valid_reg <= i_sample_valid;
      if (i_sample_valid) begin
        mag_reg <= magnitude(i_sample);
      end
    end
  end

  // Gate hold counter: runs only while every sample stays quiet
  always_ff @(posedge i_clk) begin
    if (i_reset || srst_reg || !eff_sel_reg[1] || seq_reg != SEQ_PLAY) begin
      gate_cnt_reg   <= '0;
      gate_quiet_reg <= 1'b0;
    end else if (mag_valid_reg && mag_reg >= GATE_LVL[gate_thr_reg]) begin
      gate_cnt_reg   <= '0;
      gate_quiet_reg <= 1'b0;
    end else if (gate_cnt_reg >= gate_cycles(gate_hold_reg)) begin
      gate_quiet_reg <= 1'b1;
    end else begin
      gate_cnt_reg <= gate_cnt_reg + 1'b1;
    end
  end

  // Low-power mode: hold counted in sample periods
  always_ff @(posedge i_clk) begin
    if (i_reset || srst_reg || !eff_sel_reg[0] || seq_reg != SEQ_PLAY) begin
      lp_cnt_reg <= '0;
      lp_reg     <= 1'b0;
    end else if (mag_valid_reg) begin
      if (mag_reg >= lp_thr_reg) begin
        lp_cnt_reg <= '0;
        lp_reg     <= 1'b0;
      end else if (lp_cnt_reg >= lp_time_reg) begin
        lp_reg <= 1'b1;
      end else begin
        lp_cnt_reg <= lp_cnt_reg + 24'h000001;
      end
    end
  end

  // Rail choice: low after hold, high above threshold plus hysteresis
  always_ff @(posedge i_clk) begin
    if (i_reset || srst_reg || !dual_reg || seq_reg == SEQ_OFF) begin
      lr_cnt_reg <= '0;
      o_low_rail <= 1'b0;
    end else if (mag_valid_reg && 25'(mag_reg) > 25'(lr_thr_reg) + 25'(lr_hyst_reg)) begin
      lr_cnt_reg <= '0;
      o_low_rail <= 1'b0;
    end else if (mag_valid_reg && mag_reg >= lr_thr_reg) begin
      lr_cnt_reg <= '0;
    end else if (lr_cnt_reg >= rail_cycles(lr_hold_reg)) begin
      o_low_rail <= 1'b1;
    end else begin
      lr_cnt_reg <= lr_cnt_reg + 1'b1;
    end
  end

  // Power sequencer; soft reset drops everything at once
  always_ff @(posedge i_clk) begin
    if (i_reset || srst_reg) begin
      seq_reg  <= SEQ_OFF;
      step_reg <= '0;
    end else begin
      step_reg <= step_reg + 16'h0001;
      unique case (seq_reg)
        SEQ_OFF: begin
          step_reg <= '0;
          if (want_on) begin
            seq_reg <= SEQ_POWERUP;
          end
        end
        SEQ_POWERUP: begin
          if (step_reg >= 16'(POWER_CYCLES - 1)) begin
            seq_reg  <= SEQ_RAMPUP;
            step_reg <= '0;
          end
        end
        SEQ_RAMPUP: begin
          if (step_reg >= 16'(RAMP_CYCLES - 1)) begin
            seq_reg  <= SEQ_PLAY;
            step_reg <= '0;
          end
        end
        SEQ_PLAY: begin
          step_reg <= '0;
          if (!want_on) begin
            seq_reg <= SEQ_RAMPDN;
          end else if (gate_quiet_reg) begin
            seq_reg <= SEQ_GATED;
          end
        end
        SEQ_RAMPDN: begin
          if (step_reg >= 16'(RAMP_CYCLES - 1)) begin
            seq_reg  <= SEQ_POWERDN;
            step_reg <= '0;
          end
        end
        SEQ_POWERDN: begin
          if (step_reg >= 16'(POWER_CYCLES - 1)) begin
            seq_reg  <= SEQ_OFF;
            step_reg <= '0;
          end
        end
        SEQ_GATED: begin
          step_reg <= '0;
          // Shutdown from the gate: outputs already quiet, go straight off
          if (!want_on) begin
            seq_reg <= SEQ_OFF;
          end else if (!eff_sel_reg[1]
              || (mag_valid_reg && mag_reg >= GATE_LVL[gate_thr_reg])) begin
            seq_reg <= SEQ_POWERUP;
          end
        end
        default: seq_reg <= SEQ_OFF;
      endcase
    end
  end

  // Outputs to the analog stage, all registered
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_analog_en     <= 1'b0;
      o_pwm_en        <= 1'b0;
      o_ramp_down     <= 1'b0;
      o_outputs_float <= 1'b0;
      o_sample_hold   <= 1'b0;
      pend_reg        <= 1'b0;
    end else begin
      o_analog_en <= seq_reg inside {SEQ_POWERUP, SEQ_RAMPUP, SEQ_PLAY, SEQ_RAMPDN};
      // Gate: no switching, outputs low, impedance from float select
      o_pwm_en        <= seq_reg inside {SEQ_RAMPUP, SEQ_PLAY, SEQ_RAMPDN};
      o_outputs_float <= (seq_reg == SEQ_GATED) && float_reg;
      o_ramp_down     <= (seq_reg == SEQ_RAMPDN);
      // Upstream keeps samples queued while waking from the gate
      pend_reg      <= (seq_reg == SEQ_GATED) || (pend_reg && seq_reg != SEQ_PLAY);
      o_sample_hold <= (seq_reg == SEQ_GATED) || (pend_reg && seq_reg != SEQ_PLAY);
    end
  end

  // APB slave: zero wait, unmapped reads zero with error
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        unique case (paddr)
          ADDR_CTRL:    prdata <= 32'({float_reg, 3'h0, srst_reg, 2'h0, pwr_reg});
          ADDR_EFF:     prdata <= 32'({dual_reg, 2'h0, lr_hold_reg, 2'h0, gate_hold_reg,
                                       1'b0, gate_thr_reg, 2'h0, eff_sel_reg});
          ADDR_LP_THR:  prdata <= 32'(lp_thr_reg);
          ADDR_LP_TIME: prdata <= 32'(lp_time_reg);
          ADDR_LR_THR:  prdata <= 32'(lr_thr_reg);
          ADDR_LR_HYST: prdata <= 32'(lr_hyst_reg);
          ADDR_STATUS: begin
            prdata[ST_ACTIVE_BIT]  <= (seq_reg == SEQ_PLAY);
            prdata[ST_GATE_BIT]    <= (seq_reg == SEQ_GATED);
            prdata[ST_LP_BIT]      <= lp_reg;
            prdata[ST_LOWRAIL_BIT] <= o_low_rail;
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: apm_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module apm_ctrl_assertions
  import apm_pkg::*;
#(
  parameter int unsigned CLK_LOSS = CLK_LOSS_CYC,
  parameter int unsigned HOLD_DIV = 1
) (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_config_select_pin_one,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        o_analog_en,
  input wire logic        o_pwm_en,
  input wire logic        o_ramp_down,
  input wire logic        o_outputs_float
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  // Bus steps and the soft reset write
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_srst_write;
    psel && penable && pready && pwrite && paddr == ADDR_CTRL
      && pwdata[CTRL_SRST_BIT] && !i_config_select_pin_one;
  endsequence

  a_zero_wait_answer: assert property (s_setup |=> pready)
    else $error("no answer in access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  a_pwm_needs_analog: assert property (o_pwm_en |-> o_analog_en)
    else $error("switching without analog power");
  a_powerup_order: assert property ($rose(o_analog_en) |-> !o_pwm_en [*8])
    else $error("switching too soon after power up");
  a_float_no_switch: assert property (o_outputs_float |-> !o_pwm_en)
    else $error("outputs floated while switching");
  a_ramp_while_switching: assert property (o_ramp_down |-> o_pwm_en)
    else $error("ramp without switching");
  a_reset_quiet: assert property ($fell(i_reset) |-> !o_analog_en && !o_pwm_en)
    else $error("powered after reset");
  a_soft_reset_stop: assert property (
    s_srst_write |-> ##[1:3] (!o_pwm_en && !o_analog_en))
    else $error("soft reset left channels powered");
endmodule

bind apm_ctrl apm_ctrl_assertions #(.CLK_LOSS(CLK_LOSS), .HOLD_DIV(HOLD_DIV)) u_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_config_select_pin_one(i_config_select_pin_one),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_analog_en(o_analog_en),
  .o_pwm_en(o_pwm_en), .o_ramp_down(o_ramp_down), .o_outputs_float(o_outputs_float));
`default_nettype wire

// file: apm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module apm_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_run,
  input  wire logic [23:0] i_level,
  output logic             o_bclk,
  output logic             o_frame_sync,
  output logic             o_sample_valid,
  output logic [23:0]      o_sample
);
  logic [3:0] div_reg;
  logic       sign_reg;

  // Known start for all lines
  initial begin
    div_reg = 4'h0;
    sign_reg = 1'b0;
    o_bclk = 1'b0;
    o_frame_sync = 1'b0;
    o_sample_valid = 1'b0;
    o_sample = 24'h000000;
  end

  // Sample every 16 cycles; sign alternates so only magnitude may count
  always @(posedge i_clk) begin
    o_sample_valid <= 1'b0;
    o_sample <= ~o_sample; // Line not held between samples
    if (i_run) begin
      div_reg <= div_reg + 4'h1;
      o_bclk <= ~o_bclk; // Clocks stand still when stopped
      if (div_reg == 4'h0) begin
        o_sample_valid <= 1'b1;
        o_frame_sync <= ~o_frame_sync;
        sign_reg <= ~sign_reg;
        o_sample <= sign_reg ? 24'(-i_level) : i_level;
      end
    end
  end
endmodule
`default_nettype wire

// file: apm_pkg.sv
package apm_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_EFF      = 8'h04;
  localparam logic [7:0] ADDR_LP_THR   = 8'h08;
  localparam logic [7:0] ADDR_LP_TIME  = 8'h0c;
  localparam logic [7:0] ADDR_LR_THR   = 8'h10;
  localparam logic [7:0] ADDR_LR_HYST  = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;
  // Power state codes
  localparam logic [1:0] PWR_ACTIVE    = 2'h0;
  localparam logic [1:0] PWR_SHUTDOWN  = 2'h2;
  localparam logic [1:0] PWR_CLOCKED   = 2'h3;
  // Reset values
  localparam logic [1:0] RST_PWR       = 2'h2;
  localparam logic [2:0] RST_GATE_THR  = 3'h4;
  localparam logic [1:0] RST_GATE_HOLD = 2'h1;
  localparam logic [1:0] RST_LR_HOLD   = 2'h1;
  localparam logic       RST_DUAL_RAIL = 1'b1;
  localparam logic [23:0] RST_LP_THR   = 24'h000100;
  localparam logic [23:0] RST_LP_TIME  = 24'h000400;
  localparam logic [23:0] RST_LR_THR   = 24'h010000;
  localparam logic [23:0] RST_LR_HYST  = 24'h001000;
  // Control register fields
  localparam int CTRL_PWR_LSB   = 0;
  localparam int CTRL_SRST_BIT  = 4;
  localparam int CTRL_FLOAT_BIT = 8;
  // Efficiency register fields
  localparam int EFF_SEL_LSB    = 0;
  localparam int EFF_GTHR_LSB   = 4;
  localparam int EFF_GHOLD_LSB  = 8;
  localparam int EFF_LRHOLD_LSB = 12;
  localparam int EFF_DUAL_BIT   = 16;
  // Status register fields
  localparam int ST_ACTIVE_BIT  = 1;
  localparam int ST_GATE_BIT    = 2;
  localparam int ST_LP_BIT      = 3;
  localparam int ST_LOWRAIL_BIT = 4;
  // Clock rate and times
  localparam longint CLK_HZ     = 125000000;
  localparam longint GATE_HOLD_MS [4] = '{10, 50, 100, 1000};
  localparam longint LR_HOLD_US   [4] = '{100, 500, 5000, 50000};
  // Gate threshold -85 dBFS in 24-bit magnitude, each step -5 dB
  localparam logic [23:0] GATE_LVL [8] = '{24'h000172, 24'h0000d0,
    24'h000075, 24'h000042, 24'h000025, 24'h000015, 24'h00000b, 24'h000006};
  // Sequencing step lengths in cycles
  localparam int RAMP_CYCLES    = 1024;
  localparam int POWER_CYCLES   = 256;
  localparam int CLK_LOSS_CYC   = 4096;
  localparam int CNT_W          = 32;
endpackage

// file: test_apm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_apm_ctrl;
  import apm_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        cfg_pin = 1'b0; // Tied to ground for register control
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_data;
  logic        pready, pslverr, rd_err, bclk, frame_sync, svalid;
  logic        run = 1'b1;
  logic [23:0] level = 24'h000200;
  logic [23:0] sample;
  logic        analog_en, pwm_en, ramp_down, out_float, low_rail, smp_hold;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #4 i_clk = ~i_clk;

  apm_host_model host (.i_clk(i_clk), .i_run(run), .i_level(level), .o_bclk(bclk),
    .o_frame_sync(frame_sync), .o_sample_valid(svalid), .o_sample(sample));

  // Short clock-loss window and hold times keep the run brief
  apm_ctrl #(.CLK_LOSS(512), .HOLD_DIV(1000)) dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_config_select_pin_one(cfg_pin), .i_bclk(bclk), .i_frame_sync(frame_sync),
    .i_sample_valid(svalid), .i_sample(sample), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .o_analog_en(analog_en), .o_pwm_en(pwm_en),
    .o_ramp_down(ramp_down), .o_outputs_float(out_float), .o_low_rail(low_rail),
    .o_sample_hold(smp_hold));

  task automatic stop_test;
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer; an idle edge follows so calls never collide
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_data, exp);
  endtask

  // Poll a status bit, bounded
  task automatic wait_st(input int b, input logic v);
    apb(1'b0, ADDR_STATUS, 32'h0);
    for (int k = 0; k < 2000 && rd_data[b] !== v; k++) apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd_data[b]), 32'(v));
  endtask

  // Hang guard
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      stop_test;
    end
  end

  initial begin
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    rd(ADDR_CTRL, 32'h2);
    rd(ADDR_EFF, 32'h11140);
    rd(ADDR_LP_THR, 32'h100);
    rd(ADDR_LP_TIME, 32'h400);
    rd(ADDR_LR_THR, 32'h10000);
    rd(ADDR_LR_HYST, 32'h1000);
    rd(ADDR_STATUS, 32'h0);
    rd(8'h1c, 32'h0);
    chk(32'(rd_err), 32'h1);
    // Writes ignored while the pin is high
    cfg_pin <= 1'b1;
    apb(1'b1, ADDR_LP_TIME, 32'h4);
    rd(ADDR_LP_TIME, 32'h400);
    cfg_pin <= 1'b0;
    apb(1'b1, ADDR_LP_TIME, 32'h4);
    apb(1'b1, ADDR_CTRL, 32'h0);
    rd(ADDR_LP_TIME, 32'h4);
    wait_st(ST_ACTIVE_BIT, 1'b1);
    chk(32'(pwm_en), 32'h1);
    // Core rail, hysteresis band, back to the high rail
    level <= 24'h000100;
    wait_st(ST_LOWRAIL_BIT, 1'b1);
    chk(32'(low_rail), 32'h1);
    level <= 24'h010800;
    repeat (200) @(posedge i_clk);
    chk(32'(low_rail), 32'h1);
    level <= 24'h011100;
    wait_st(ST_LOWRAIL_BIT, 1'b0);
    // Low-power mode with the dual rail off
    apb(1'b1, ADDR_EFF, 32'h1141);
    level <= 24'h000080;
    wait_st(ST_LP_BIT, 1'b1);
    repeat (100) @(posedge i_clk);
    chk(32'(low_rail), 32'h0);
    level <= 24'h000200;
    wait_st(ST_LP_BIT, 1'b0);
    chk(32'(pwm_en), 32'h1);
    // Gate at the top threshold, shortest hold, outputs floated
    apb(1'b1, ADDR_CTRL, 32'h100);
    apb(1'b1, ADDR_EFF, 32'h1002);
    level <= 24'h000100;
    repeat (600) @(posedge i_clk);
    rd(ADDR_STATUS, 32'h2);
    wait_st(ST_GATE_BIT, 1'b1);
    chk(32'(pwm_en), 32'h0);
    chk(32'(out_float), 32'h1);
    chk(32'(smp_hold), 32'h1);
    level <= 24'h000200;
    wait_st(ST_GATE_BIT, 1'b0);
    wait_st(ST_ACTIVE_BIT, 1'b1);
    chk(32'(smp_hold), 32'h0);
    // Shutdown ramps down and keeps settings
    apb(1'b1, ADDR_CTRL, 32'h2);
    repeat (4) @(posedge i_clk);
    chk(32'(ramp_down), 32'h1);
    wait_st(ST_ACTIVE_BIT, 1'b0);
    repeat (1400) @(posedge i_clk);
    chk(32'(analog_en), 32'h0);
    rd(ADDR_EFF, 32'h1002);
    // Clock-driven state follows the host clocks
    apb(1'b1, ADDR_CTRL, 32'h3);
    wait_st(ST_ACTIVE_BIT, 1'b1);
    level <= 24'h000000;
    run <= 1'b0;
    repeat (2000) @(posedge i_clk);
    chk(32'(analog_en), 32'h0);
    run <= 1'b1;
    level <= 24'h000200;
    wait_st(ST_ACTIVE_BIT, 1'b1);
    // Soft reset while playing
    apb(1'b1, ADDR_CTRL, 32'h13);
    repeat (2) @(posedge i_clk);
    chk(32'(pwm_en), 32'h0);
    rd(ADDR_CTRL, 32'h2);
    rd(ADDR_EFF, 32'h11140);
    stop_test;
  end
endmodule
`default_nettype wire
